// ===== rtl/cop_pkg.sv
`default_nettype none
package cop_pkg;
  localparam int LINES          = 2;
  localparam int CELLS_PER_LINE = 16;
  localparam int GLYPH_COLS     = 5;
  localparam int GLYPH_ROWS     = 8;
  localparam int DUTY_COMMONS   = 16;

  localparam logic [6:0] LINE1_BASE = 7'h00;
  localparam logic [6:0] LINE2_BASE = 7'h40;
  localparam logic [6:0] LINE1_LAST = 7'h0F;
  localparam logic [6:0] LINE2_LAST = 7'h4F;

  // Bit positions inside the synchronised pin vector.
  localparam int SY_RESET = 0;
  localparam int SY_CS    = 1;
  localparam int SY_DC    = 2;
  localparam int SY_GPIO  = 3;
  localparam int SY_PROTO = 4;
  localparam int SY_SCAN  = 7;
  localparam int SY_SEG   = 8;
  localparam int SY_TABLE = 9;
  localparam int SY_SPLIT = 11;
  localparam int SY_W     = 13;

  // Protocol strap codes, written as {strap2, strap1, strap0}.
  localparam logic [2:0] STRAP_I2C   = 3'h2;
  localparam logic [2:0] STRAP_SPI   = 3'h0;
  localparam logic [2:0] STRAP_P4_68 = 3'h5;
  localparam logic [2:0] STRAP_P4_80 = 3'h7;
  localparam logic [2:0] STRAP_P8_68 = 3'h4;
  localparam logic [2:0] STRAP_P8_80 = 3'h6;

  typedef enum logic [2:0] {
    COP_PROTO_I2C   = 3'h0,
    COP_PROTO_SPI   = 3'h1,
    COP_PROTO_P4_68 = 3'h2,
    COP_PROTO_P4_80 = 3'h3,
    COP_PROTO_P8_68 = 3'h4,
    COP_PROTO_P8_80 = 3'h5,
    COP_PROTO_BAD   = 3'h7
  } cop_proto_t;

  // Glyph table codes follow {strap1, strap0} directly.
  typedef enum logic [1:0] {
    COP_TABLE_A    = 2'h0,
    COP_TABLE_B    = 2'h1,
    COP_TABLE_C    = 2'h2,
    COP_TABLE_SOFT = 2'h3
  } cop_table_t;
  localparam cop_table_t TABLE_SOFT_DEFAULT = COP_TABLE_A;

  // Split codes follow {strap1, strap0}.
  localparam logic [1:0] SPLIT_240_8 = 2'h0;
  localparam logic [1:0] SPLIT_248_8 = 2'h1;
  localparam logic [1:0] SPLIT_250_6 = 2'h2;
  localparam logic [1:0] SPLIT_256_0 = 2'h3;
  localparam logic [8:0] FIXED_240   = 9'h0F0;
  localparam logic [8:0] FIXED_248   = 9'h0F8;
  localparam logic [8:0] FIXED_250   = 9'h0FA;
  localparam logic [8:0] FIXED_256   = 9'h100;
  localparam logic [3:0] USER_8      = 4'h8;
  localparam logic [3:0] USER_6      = 4'h6;
  localparam logic [3:0] USER_0      = 4'h0;

  typedef enum logic [1:0] {
    COP_GPIO_OPEN   = 2'h0,
    COP_GPIO_INPUT  = 2'h1,
    COP_GPIO_OUTPUT = 2'h2,
    COP_GPIO_DCDC   = 2'h3
  } cop_gpio_t;

  typedef enum logic [1:0] {
    COP_ST_INIT = 2'h0,
    COP_ST_RUN  = 2'h1
  } cop_state_t;

  localparam logic DIR_RESET = 1'b0;
  localparam int   SCAN_DIV_DEFAULT = 16;
endpackage
`default_nettype wire

// ===== rtl/cop_sync_if.sv
`default_nettype none
interface cop_sync_if #(parameter int W = 1);
  logic [W-1:0] q;
  modport src (output q);
  modport dst (input q);
endinterface
`default_nettype wire

// ===== rtl/cop_sync.sv
`default_nettype none
module cop_sync #(
  parameter int W = 1
) (
  input  wire logic   mclk,
  input  wire logic   rst,
  input  wire logic [W-1:0] d,
  cop_sync_if.src     out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  if (W < 1) begin
    $error("cop_sync width must be at least one");
  end

  // The first stage feeds only the second stage.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      q_reg    <= '0;
    end else begin
      meta_reg <= d;
      q_reg    <= meta_reg;
    end
  end

  assign out.q = q_reg;
endmodule
`default_nettype wire

// ===== rtl/cop_host_port.sv
`default_nettype none
module cop_host_port #(
  parameter int SCAN_DIV = cop_pkg::SCAN_DIV_DEFAULT
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        reset_n_in,
  input  wire logic        csPin_n,
  input  wire logic        dcPin,
  input  wire logic        proto_strap_0,
  input  wire logic        proto_strap_1,
  input  wire logic        proto_strap_2,
  input  wire logic        common_scan_dir_strap,
  input  wire logic        segment_map_dir_strap,
  input  wire logic        glyph_table_strap_0,
  input  wire logic        glyph_table_strap_1,
  input  wire logic        glyph_split_strap_0,
  input  wire logic        glyph_split_strap_1,
  input  wire logic        cmdScanWe,
  input  wire logic        cmdScanDir,
  input  wire logic        cmdSegWe,
  input  wire logic        cmdSegDir,
  input  wire logic        cmdTableWe,
  input  wire logic [1:0]  cmdTable,
  input  wire logic        cmdSplitWe,
  input  wire logic [1:0]  cmdSplit,
  input  wire logic [1:0]  gpioMode,
  input  wire logic        gpioOutValue,
  input  wire logic        dcdcEnable,
  input  wire logic        gpioPinIn,
  input  wire logic        cellLine,
  input  wire logic [3:0]  cellPos,
  output logic             gpioPinOut_reg,
  output logic             gpioPinOe_reg,
  output logic             gpioIn_reg,
  output logic             initBusy_reg,
  output logic [2:0]       proto_reg,
  output logic             protoBad_reg,
  output logic             accessEnable_reg,
  output logic             isData_reg,
  output logic             i2cAddrSel_reg,
  output logic [1:0]       glyphTable_reg,
  output logic [8:0]       fixedGlyphCount_reg,
  output logic [3:0]       userGlyphCount_reg,
  output logic             scanDir_reg,
  output logic             segDir_reg,
  output logic [3:0]       commonIndex_reg,
  output logic [6:0]       ddramAddr_reg
);
  localparam int DW = $clog2(SCAN_DIV + 1);

  if (SCAN_DIV < 1) begin
    $error("SCAN_DIV must be at least one");
  end
  if (cop_pkg::DUTY_COMMONS != 16) begin
    $error("common index is four bits wide");
  end

  cop_sync_if #(.W(cop_pkg::SY_W)) syn ();
  logic [cop_pkg::SY_W-1:0] pinsRaw;
  assign pinsRaw = {glyph_split_strap_1, glyph_split_strap_0,
                    glyph_table_strap_1, glyph_table_strap_0,
                    segment_map_dir_strap, common_scan_dir_strap,
                    proto_strap_2, proto_strap_1, proto_strap_0,
                    gpioPinIn, dcPin, csPin_n, reset_n_in};

  cop_sync #(.W(cop_pkg::SY_W)) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .d    (pinsRaw),
    .out  (syn)
  );

  logic resetPin_n;
  logic csSync_n;
  logic dcSync;
  logic [2:0] protoStrap;
  logic [1:0] tableStrap;
  logic [1:0] splitStrap;
  assign resetPin_n = syn.q[cop_pkg::SY_RESET];
  assign csSync_n   = syn.q[cop_pkg::SY_CS];
  assign dcSync     = syn.q[cop_pkg::SY_DC];
  assign protoStrap = syn.q[cop_pkg::SY_PROTO +: 3];
  assign tableStrap = syn.q[cop_pkg::SY_TABLE +: 2];
  assign splitStrap = syn.q[cop_pkg::SY_SPLIT +: 2];

  cop_pkg::cop_state_t state_reg;
  logic running;
  assign running = (state_reg == cop_pkg::COP_ST_RUN) && resetPin_n;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= cop_pkg::COP_ST_INIT;
    end else begin
      case (state_reg)
        cop_pkg::COP_ST_INIT: if (resetPin_n) state_reg <= cop_pkg::COP_ST_RUN;
        cop_pkg::COP_ST_RUN:  if (!resetPin_n) state_reg <= cop_pkg::COP_ST_INIT;
        default:              state_reg <= cop_pkg::COP_ST_INIT;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) initBusy_reg <= 1'b1;
    else initBusy_reg <= !running;
  end

  // Straps are only sampled during initialisation, so a pin that moves later
  // cannot disturb a running configuration.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      proto_reg    <= cop_pkg::COP_PROTO_SPI;
      protoBad_reg <= 1'b0;
    end else if (state_reg == cop_pkg::COP_ST_INIT) begin
      protoBad_reg <= 1'b0;
      case (protoStrap)
        cop_pkg::STRAP_I2C:   proto_reg <= cop_pkg::COP_PROTO_I2C;
        cop_pkg::STRAP_SPI:   proto_reg <= cop_pkg::COP_PROTO_SPI;
        cop_pkg::STRAP_P4_68: proto_reg <= cop_pkg::COP_PROTO_P4_68;
        cop_pkg::STRAP_P4_80: proto_reg <= cop_pkg::COP_PROTO_P4_80;
        cop_pkg::STRAP_P8_68: proto_reg <= cop_pkg::COP_PROTO_P8_68;
        cop_pkg::STRAP_P8_80: proto_reg <= cop_pkg::COP_PROTO_P8_80;
        default: begin
          proto_reg    <= cop_pkg::COP_PROTO_BAD;
          protoBad_reg <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      glyphTable_reg <= cop_pkg::TABLE_SOFT_DEFAULT;
    end else if (state_reg == cop_pkg::COP_ST_INIT) begin
      if (tableStrap == cop_pkg::COP_TABLE_SOFT) glyphTable_reg <= cop_pkg::TABLE_SOFT_DEFAULT;
      else glyphTable_reg <= tableStrap;
    end else if (cmdTableWe && running) begin
      glyphTable_reg <= cmdTable;
    end
  end

  logic [1:0] splitNext;
  always_comb begin
    splitNext = splitStrap;
    if (state_reg != cop_pkg::COP_ST_INIT) splitNext = cmdSplit;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fixedGlyphCount_reg <= cop_pkg::FIXED_240;
      userGlyphCount_reg  <= cop_pkg::USER_8;
    end else if (state_reg == cop_pkg::COP_ST_INIT || (cmdSplitWe && running)) begin
      case (splitNext)
        cop_pkg::SPLIT_240_8: begin
          fixedGlyphCount_reg <= cop_pkg::FIXED_240;
          userGlyphCount_reg  <= cop_pkg::USER_8;
        end
        cop_pkg::SPLIT_248_8: begin
          fixedGlyphCount_reg <= cop_pkg::FIXED_248;
          userGlyphCount_reg  <= cop_pkg::USER_8;
        end
        cop_pkg::SPLIT_250_6: begin
          fixedGlyphCount_reg <= cop_pkg::FIXED_250;
          userGlyphCount_reg  <= cop_pkg::USER_6;
        end
        default: begin
          fixedGlyphCount_reg <= cop_pkg::FIXED_256;
          userGlyphCount_reg  <= cop_pkg::USER_0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scanDir_reg <= cop_pkg::DIR_RESET;
      segDir_reg  <= cop_pkg::DIR_RESET;
    end else if (state_reg == cop_pkg::COP_ST_INIT) begin
      scanDir_reg <= syn.q[cop_pkg::SY_SCAN];
      segDir_reg  <= syn.q[cop_pkg::SY_SEG];
    end else if (running) begin
      if (cmdScanWe) scanDir_reg <= cmdScanDir;
      if (cmdSegWe) segDir_reg <= cmdSegDir;
    end
  end

  logic [DW-1:0] scanCount_reg;
  logic          scanTick;
  assign scanTick = (scanCount_reg == DW'(SCAN_DIV - 1));

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) scanCount_reg <= '0;
    else if (!running || scanTick) scanCount_reg <= '0;
    else scanCount_reg <= scanCount_reg + DW'(1);
  end

  // Four bits wrap naturally through the sixteen commons of the duty cycle.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) commonIndex_reg <= 4'h0;
    else if (!running) commonIndex_reg <= 4'h0;
    else if (scanTick && scanDir_reg) commonIndex_reg <= commonIndex_reg - 4'h1;
    else if (scanTick) commonIndex_reg <= commonIndex_reg + 4'h1;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) ddramAddr_reg <= cop_pkg::LINE1_BASE;
    else if (cellLine) ddramAddr_reg <= cop_pkg::LINE2_BASE | {3'h0, cellPos};
    else ddramAddr_reg <= cop_pkg::LINE1_BASE | {3'h0, cellPos};
  end

  logic isI2c;
  assign isI2c = (proto_reg == cop_pkg::COP_PROTO_I2C);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      accessEnable_reg <= 1'b0;
      isData_reg       <= 1'b0;
      i2cAddrSel_reg   <= 1'b0;
    end else begin
      accessEnable_reg <= running && !csSync_n && !protoBad_reg;
      isData_reg       <= running && !isI2c && dcSync;
      i2cAddrSel_reg   <= isI2c && dcSync;
    end
  end

  // An open pin is never driven, so a floating board net cannot fight us.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gpioPinOut_reg <= 1'b0;
      gpioPinOe_reg  <= 1'b0;
      gpioIn_reg     <= 1'b0;
    end else begin
      gpioIn_reg     <= (gpioMode == cop_pkg::COP_GPIO_INPUT) && syn.q[cop_pkg::SY_GPIO];
      gpioPinOe_reg  <= running && (gpioMode == cop_pkg::COP_GPIO_OUTPUT ||
                                    gpioMode == cop_pkg::COP_GPIO_DCDC);
      gpioPinOut_reg <= (gpioMode == cop_pkg::COP_GPIO_DCDC) ? dcdcEnable : gpioOutValue;
    end
  end

  sequence s_release;
    (state_reg == cop_pkg::COP_ST_INIT) ##1 (state_reg == cop_pkg::COP_ST_RUN);
  endsequence

  a_init_blocks_access: assert property (@(posedge mclk) disable iff (rst)
    !resetPin_n |=> initBusy_reg && !accessEnable_reg) else $error("access during init");
  a_cs_gates_access: assert property (@(posedge mclk) disable iff (rst)
    accessEnable_reg |-> $past(!csSync_n)) else $error("access without chip select");
  a_straps_frozen: assert property (@(posedge mclk) disable iff (rst)
    s_release ##1 (state_reg == cop_pkg::COP_ST_RUN) |-> $stable(proto_reg))
    else $error("protocol moved while running");
  a_ddram_range: assert property (@(posedge mclk) disable iff (rst)
    (ddramAddr_reg <= cop_pkg::LINE1_LAST) ||
    (ddramAddr_reg >= cop_pkg::LINE2_BASE && ddramAddr_reg <= cop_pkg::LINE2_LAST))
    else $error("display address outside both lines");
  a_split_pairs: assert property (@(posedge mclk) disable iff (rst)
    (fixedGlyphCount_reg == cop_pkg::FIXED_240 && userGlyphCount_reg == cop_pkg::USER_8) ||
    (fixedGlyphCount_reg == cop_pkg::FIXED_248 && userGlyphCount_reg == cop_pkg::USER_8) ||
    (fixedGlyphCount_reg == cop_pkg::FIXED_250 && userGlyphCount_reg == cop_pkg::USER_6) ||
    (fixedGlyphCount_reg == cop_pkg::FIXED_256 && userGlyphCount_reg == cop_pkg::USER_0))
    else $error("illegal glyph split");
  a_scan_cmd: assert property (@(posedge mclk) disable iff (rst)
    (running && cmdScanWe) |=> scanDir_reg == $past(cmdScanDir))
    else $error("scan command ignored");
  a_seg_cmd: assert property (@(posedge mclk) disable iff (rst)
    (running && cmdSegWe) |=> segDir_reg == $past(cmdSegDir))
    else $error("segment command ignored");
  a_table_cmd: assert property (@(posedge mclk) disable iff (rst)
    (running && cmdTableWe) |=> glyphTable_reg == $past(cmdTable))
    else $error("table command ignored");
  a_scan_step: assert property (@(posedge mclk) disable iff (rst)
    (running && scanTick && !scanDir_reg && !cmdScanWe) ##1 running |->
    commonIndex_reg == $past(commonIndex_reg) + 4'h1) else $error("common index did not step");
  a_i2c_no_data: assert property (@(posedge mclk) disable iff (rst)
    isI2c |=> !isData_reg) else $error("data marked in I2C mode");
  a_dc_marks_data: assert property (@(posedge mclk) disable iff (rst)
    (running && !isI2c && dcSync) |=> isData_reg) else $error("data select not honoured");
  a_gpio_open: assert property (@(posedge mclk) disable iff (rst)
    gpioMode == cop_pkg::COP_GPIO_OPEN |=> !gpioPinOe_reg) else $error("open pin driven");
endmodule
`default_nettype wire

// ===== sim/cop_host_model.sv
`default_nettype none
// Host side of the pins: reset, chip select, data/command and straps.
module cop_host_model (
  input  wire logic       mclk,
  output logic            reset_n_in,
  output logic            csPin_n,
  output logic            dcPin,
  output logic [2:0]      protoStraps,
  output logic [7:0]      cfgStraps
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    reset_n_in = 1'b1;
    csPin_n = 1'b1;
    dcPin = 1'b0;
    protoStraps = 3'h0;
    cfgStraps = 8'h00;
  end

  // Straps move only while the reset pin is low, so a run never sees them change.
  task automatic boot(input logic [2:0] proto, input logic [7:0] cfg);
    @(posedge mclk);
    reset_n_in <= 1'b0;
    protoStraps <= proto;
    cfgStraps <= cfg;
    repeat (8) @(posedge mclk);
    reset_n_in <= 1'b1;
  endtask

  task automatic access(input logic isData);
    @(posedge mclk);
    csPin_n <= 1'b0;
    dcPin <= isData;
  endtask

  // On release chip select goes high and dcPin is flipped so that a stale level is never trusted.
  task automatic releaseBus();
    @(posedge mclk);
    csPin_n <= 1'b1;
    dcPin <= ~dcPin;
  endtask
endmodule
`default_nettype wire

// ===== sim/cop_host_port_tb.sv
`default_nettype none
module cop_host_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DIV = 2;
  logic            mclk, rst, cmdScanWe, cmdScanDir, cmdSegWe, cmdSegDir;
  logic            cmdTableWe, cmdSplitWe, gpioOutValue, dcdcEnable, hostGpio, cellLine;
  logic [1:0]      cmdTable, cmdSplit, gpioMode;
  logic [3:0]      cellPos, commonIndex_reg, userGlyphCount_reg;
  logic            gpioPinOut_reg, gpioPinOe_reg, gpioIn_reg, initBusy_reg, protoBad_reg;
  logic            accessEnable_reg, isData_reg, i2cAddrSel_reg, scanDir_reg, segDir_reg;
  logic [2:0]      proto_reg;
  logic [1:0]      glyphTable_reg;
  logic [8:0]      fixedGlyphCount_reg;
  logic [6:0]      ddramAddr_reg;
  wire logic       reset_n_in, csPin_n, dcPin;
  wire logic [2:0] ps;
  wire logic [7:0] cfg;
  // The pin level is the device's value while it drives, else the host's.
  wire logic       gpioPinIn = gpioPinOe_reg ? gpioPinOut_reg : hostGpio;
  int              comparisons = 0;
  int              miscompares = 0;

  cop_host_port #(.SCAN_DIV(DIV)) uut (.mclk, .rst, .reset_n_in, .csPin_n, .dcPin,
    .proto_strap_0(ps[0]), .proto_strap_1(ps[1]), .proto_strap_2(ps[2]),
    .common_scan_dir_strap(cfg[0]), .segment_map_dir_strap(cfg[1]),
    .glyph_table_strap_0(cfg[2]), .glyph_table_strap_1(cfg[3]),
    .glyph_split_strap_0(cfg[4]), .glyph_split_strap_1(cfg[5]),
    .cmdScanWe, .cmdScanDir, .cmdSegWe, .cmdSegDir, .cmdTableWe, .cmdTable,
    .cmdSplitWe, .cmdSplit, .gpioMode, .gpioOutValue, .dcdcEnable, .gpioPinIn,
    .cellLine, .cellPos, .gpioPinOut_reg, .gpioPinOe_reg, .gpioIn_reg, .initBusy_reg,
    .proto_reg, .protoBad_reg, .accessEnable_reg, .isData_reg, .i2cAddrSel_reg,
    .glyphTable_reg, .fixedGlyphCount_reg, .userGlyphCount_reg, .scanDir_reg,
    .segDir_reg, .commonIndex_reg, .ddramAddr_reg);
  cop_host_model host (.mclk, .reset_n_in, .csPin_n, .dcPin, .protoStraps(ps),
    .cfgStraps(cfg));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic checkVec(input string what, input logic [8:0] exp, input logic [8:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic checkBit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic waitIdle();
    for (int n = 0; n < 40; n++) begin
      @(negedge mclk);
      if (initBusy_reg === 1'b0) return;
    end
    miscompares++;
    tally_and_finish();
  endtask

  task automatic boot(input logic [2:0] p, input logic [7:0] c);
    host.boot(p, c);
    waitIdle();
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic glyphs(input logic [1:0] t, input logic [8:0] f, input logic [3:0] u);
    checkVec("table", 9'(t), 9'(glyphTable_reg));
    checkVec("fixed", f, fixedGlyphCount_reg);
    checkVec("user", 9'(u), 9'(userGlyphCount_reg));
  endtask

  task automatic testStraps();
    logic [2:0] pc [6] = '{cop_pkg::STRAP_I2C, cop_pkg::STRAP_SPI, cop_pkg::STRAP_P4_68,
                           cop_pkg::STRAP_P4_80, cop_pkg::STRAP_P8_68, cop_pkg::STRAP_P8_80};
    logic [8:0] fx [4] = '{cop_pkg::FIXED_240, cop_pkg::FIXED_248, cop_pkg::FIXED_250,
                           cop_pkg::FIXED_256};
    logic [3:0] us [4] = '{cop_pkg::USER_8, cop_pkg::USER_8, cop_pkg::USER_6, cop_pkg::USER_0};
    logic [1:0] t;
    logic [1:0] s;
    for (int i = 0; i < 6; i++) begin
      t = 2'(i);
      s = 2'(i + 1);
      boot(pc[i], {2'b00, s, t, 2'(i)});
      checkVec("proto", 9'(i), 9'(proto_reg));
      checkBit("protoBad", 1'b0, protoBad_reg);
      glyphs((t == 2'h3) ? cop_pkg::TABLE_SOFT_DEFAULT : t, fx[s], us[s]);
      checkBit("scanDir", i[0], scanDir_reg);
      checkBit("segDir", i[1], segDir_reg);
      host.access(1'b1);
      settle(4);
      checkBit("access", 1'b1, accessEnable_reg);
      checkBit("isData", i != 0, isData_reg);
      checkBit("i2cAddr", i == 0, i2cAddrSel_reg);
      host.releaseBus();
    end
    boot(3'h1, 8'h00);
    checkBit("protoBad", 1'b1, protoBad_reg);
    checkVec("proto", 9'(cop_pkg::COP_PROTO_BAD), 9'(proto_reg));
    host.access(1'b1);
    settle(4);
    checkBit("access", 1'b0, accessEnable_reg);
    host.releaseBus();
  endtask

  task automatic pulse(input logic [1:0] tb, input logic [1:0] sp, input logic dir);
    @(posedge mclk);
    {cmdTableWe, cmdSplitWe, cmdScanWe, cmdSegWe} <= 4'hF;
    cmdTable <= tb;
    cmdSplit <= sp;
    cmdScanDir <= dir;
    cmdSegDir <= ~dir;
    @(posedge mclk);
    {cmdTableWe, cmdSplitWe, cmdScanWe, cmdSegWe} <= 4'h0;
    settle(1);
  endtask

  task automatic testCommands();
    fork
      host.boot(cop_pkg::STRAP_SPI, 8'h3F);
      begin
        repeat (5) @(posedge mclk);
        host.access(1'b1);
        settle(3);
        checkBit("accessInit", 1'b0, accessEnable_reg);
      end
    join
    waitIdle();
    settle(1);
    checkBit("isData", 1'b1, isData_reg);
    pulse(2'h2, 2'h2, 1'b0);
    glyphs(2'h2, cop_pkg::FIXED_250, cop_pkg::USER_6);
    checkBit("scanCmd", 1'b0, scanDir_reg);
    checkBit("segCmd", 1'b1, segDir_reg);
    pulse(2'h3, 2'h0, 1'b1);
    glyphs(2'h3, cop_pkg::FIXED_240, cop_pkg::USER_8);
    checkBit("scanCmd", 1'b1, scanDir_reg);
    checkBit("segCmd", 1'b0, segDir_reg);
    host.access(1'b0);
    settle(4);
    checkBit("isData", 1'b0, isData_reg);
    checkBit("access", 1'b1, accessEnable_reg);
    host.releaseBus();
    settle(4);
    checkBit("access", 1'b0, accessEnable_reg);
  endtask

  task automatic testGpio();
    for (int m = 0; m < 4; m++) begin
      @(posedge mclk);
      gpioMode <= 2'(m);
      gpioOutValue <= ~m[0];
      dcdcEnable <= m[0];
      settle(4);
      checkBit("gpioOe", m >= 2, gpioPinOe_reg);
      if (m >= 2) checkBit("gpioOut", 1'b1, gpioPinOut_reg);
      checkBit("gpioIn", m == 1, gpioIn_reg);
      if (m == 1) begin
        @(posedge mclk);
        hostGpio <= 1'b0;
        settle(4);
        checkBit("gpioInLow", 1'b0, gpioIn_reg);
        @(posedge mclk);
        hostGpio <= 1'b1;
      end
    end
  endtask

  task automatic testAddr();
    for (int k = 0; k < 32; k++) begin
      @(posedge mclk);
      cellLine <= k[4];
      cellPos <= k[3:0];
      settle(1);
      checkVec("ddram", 9'((k[4] ? cop_pkg::LINE2_BASE : cop_pkg::LINE1_BASE) | 7'(k[3:0])),
               9'(ddramAddr_reg));
    end
  endtask

  // Direction is 1 here, so the common index must count down.
  task automatic testScan();
    logic [3:0] a;
    a = commonIndex_reg;
    settle(3 * DIV);
    checkVec("common", 9'(4'(a - 4'h3)), 9'(commonIndex_reg));
    settle(cop_pkg::DUTY_COMMONS * DIV);
    checkVec("commonWrap", 9'(4'(a - 4'h3)), 9'(commonIndex_reg));
  endtask

  initial begin
    rst = 1'b1;
    {cmdScanWe, cmdScanDir, cmdSegWe, cmdSegDir, cmdTableWe, cmdSplitWe} = 6'h00;
    {cmdTable, cmdSplit, gpioMode, cellPos} = 10'h000;
    {gpioOutValue, dcdcEnable, cellLine} = 3'h0;
    hostGpio = 1'b1;
    settle(4);
    checkBit("initBusy", 1'b1, initBusy_reg);
    checkVec("proto", 9'(cop_pkg::COP_PROTO_SPI), 9'(proto_reg));
    glyphs(2'h0, cop_pkg::FIXED_240, cop_pkg::USER_8);
    checkVec("ddram", 9'h000, 9'(ddramAddr_reg));
    @(posedge mclk);
    rst <= 1'b0;
    testStraps();
    testCommands();
    testGpio();
    testAddr();
    testScan();
    tally_and_finish();
  end
endmodule
`default_nettype wire
